// File: logic/charge_count_pkg.sv
// ****************************************************************************
// Shared constants and types for the charge counter back end.
// ****************************************************************************
package charge_count_pkg;

   // Core clock rate in MHz (period 20 ns).
   localparam int CLK_MHZ = 50;

   // Least clear low time before the flag releases, in microseconds.
   localparam int CLEAR_MIN_US = 20;
   // Cycles that the clear must exceed while low.
   localparam int CLEAR_CYC = CLEAR_MIN_US * CLK_MHZ;

   // Least interrupt low time, in microseconds.
   localparam int INT_MIN_US = 1;
   // Cycles that the interrupt must stand low at least.
   localparam int INT_MIN_CYC = INT_MIN_US * CLK_MHZ;

   // Least initialisation interval after reset or wake, in milliseconds.
   localparam int INIT_MIN_MS = 5;
   // Cycles of the initialisation interval.
   localparam int INIT_CYC = INIT_MIN_MS * 1000 * CLK_MHZ;

   // Extra time before the count tracks the sense voltage, in milliseconds.
   localparam int SETTLE_MS = 80;
   // Cycles of the settling interval.
   localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;

   // Ramp interval at full-scale input, in microseconds.
   localparam int RAMP_FS_US = 600;
   // Cycles of the shortest legal ramp interval.
   localparam int RAMP_FS_CYC = RAMP_FS_US * CLK_MHZ;

   // Width of the clear filter counter.
   localparam int CLEAR_W = 11;
   // Width of the interrupt age counter.
   localparam int AGE_W = 7;

   // Wide timer used for initialisation, settling and ramp spacing.
   typedef logic [22:0] timer_type;
   // Signed charge counter.
   typedef logic signed [11:0] count_type;
   // Clear filter counter.
   typedef logic [CLEAR_W-1:0] clear_cnt_type;
   // Interrupt age counter.
   typedef logic [AGE_W-1:0] age_type;

   // Counter reference value and the two wrap points, 1024 steps away.
   localparam count_type COUNT_REF    = 12'sh000;
   localparam count_type COUNT_TOP    = 12'sh400;
   localparam count_type COUNT_BOTTOM = 12'shc00;
   localparam count_type COUNT_UP     = 12'sh001;
   localparam count_type COUNT_DOWN   = 12'shfff;

   // Filter count at which the clear has been low longer than the minimum.
   localparam clear_cnt_type CLEAR_HIT = clear_cnt_type'(CLEAR_CYC + 1);
   // Age at which the interrupt has stood low long enough.
   localparam age_type INT_AGE_MIN = age_type'(INT_MIN_CYC);

   // One-hot operating modes.
   typedef enum logic [2:0]
   {
      ST_SLEEP = 3'h1,
      ST_INIT  = 3'h2,
      ST_RUN   = 3'h4
   } mode_type;

endpackage

// File: logic/clear_width_filter.sv
`timescale 1ns/10ps
// ****************************************************************************
// Clear input width filter.
// ****************************************************************************
module clear_width_filter
(
   input  wire logic i_mclk,         // Core clock.
   input  wire logic i_reset_n,      // Synchronous reset, active low.
   input  wire logic i_enable,       // High while the counter runs.
   input  wire logic i_flag_clear_n, // Clear input, active low.
   output logic      o_clear_hit     // Clear held low past the minimum.
);

   // State of the filter.
   typedef struct packed
   {
      charge_count_pkg::clear_cnt_type cnt; // Low time seen so far.
      logic                            hit; // Registered result.
   } filt_state_type;

   filt_state_type s_r;   // Present state.
   filt_state_type s_nxt; // Next state.

   // ************************************************************************
   // Next state.
   // ************************************************************************
   // Counts low samples and saturates, so a short glitch never releases.
   always_comb
   begin
      s_nxt = s_r;
      if (!i_enable || i_flag_clear_n)
      begin
         // A high sample restarts the measurement.
         s_nxt.cnt = '0;
      end
      else if (s_r.cnt != charge_count_pkg::CLEAR_HIT)
      begin
         // Still low and not yet long enough.
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
      s_nxt.hit = (s_nxt.cnt == charge_count_pkg::CLEAR_HIT);
   end

   // ************************************************************************
   // State register.
   // ************************************************************************
   // Registers the state on every edge.
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign o_clear_hit = s_r.hit;

endmodule // clear_width_filter

// File: logic/charge_count_interrupt_logic.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Each ramp reversal steps counter up or down.
// - 1024 reversals between successive charge interrupts.
// - Overflow or underflow latches interrupt low.
// - Direction latched with the interrupt event.
// - Direction low means leaving, released means entering.
// - Unlatched direction output shows live direction.
// - Clear low over 20 us releases interrupt.
// - Counting continues while latched or clearing.
// - Looped clear: interrupt low at least 1 us.
// - Sleep request resets all logic.
// - Sleep releases both open-drain outputs.
// - Waking runs a fresh initialisation interval.
// - Power-up waits at least 5 ms.
// - Tracking valid only 80 ms later.
// - Undervoltage below 2.5 V resets everything.
// - Reset discards the accumulated count.
// - Direction from both switches and ramp.
// - Full-scale ramp interval is 600 us.
// - Clear also unlatches direction output.
module charge_count_interrupt_logic
#(
   parameter int INIT_CYC    = charge_count_pkg::INIT_CYC,   // Initialisation cycles.
   parameter int SETTLE_CYC  = charge_count_pkg::SETTLE_CYC, // Settling cycles.
   parameter int RAMP_FS_CYC = charge_count_pkg::RAMP_FS_CYC // Full-scale ramp cycles.
)
(
   input  wire logic i_mclk,                   // Core clock, 50 MHz.
   input  wire logic i_reset_n,                // Power-on reset, active low.
   input  wire logic i_sleep_request_n,        // Shutdown request, active low.
   input  wire logic i_undervoltage,           // Supply below lockout level.
   input  wire logic i_ramp_rising,            // Present integrator ramp direction.
   input  wire logic i_ramp_switch_a,          // State of reversing switch A.
   input  wire logic i_ramp_switch_b,          // State of reversing switch B.
   input  wire logic i_flag_clear_n,           // Interrupt clear, active low.
   output logic      o_charge_int_n,           // Interrupt pin drive level.
   output logic      o_charge_int_oe_n,        // Interrupt pin enable, low drives.
   output logic      o_current_direction_out,  // Direction pin drive level.
   output logic      o_current_direction_oe_n, // Direction pin enable, low drives.
   output logic      o_tracking_valid,         // Count tracks the sense voltage.
   output logic      o_overrange,              // Reversals came faster than full scale.
   output logic      o_count_lost              // A unit arrived while still latched.
);

   // ************************************************************************
   // Local constants.
   // ************************************************************************
   // Last cycle of the initialisation interval.
   localparam charge_count_pkg::timer_type INIT_LAST   = charge_count_pkg::timer_type'(INIT_CYC - 1);
   // Last cycle of the settling interval.
   localparam charge_count_pkg::timer_type SETTLE_LAST = charge_count_pkg::timer_type'(SETTLE_CYC - 1);
   // Shortest legal spacing between reversals.
   localparam charge_count_pkg::timer_type RAMP_LAST   = charge_count_pkg::timer_type'(RAMP_FS_CYC - 1);

   // ************************************************************************
   // State.
   // ************************************************************************
   // All state of the block.
   typedef struct packed
   {
      charge_count_pkg::mode_type  mode;       // Operating mode.
      charge_count_pkg::timer_type timer;      // Init and settling timer.
      charge_count_pkg::timer_type spacing;    // Cycles since last reversal.
      logic                        seen_rev;   // One reversal seen already.
      charge_count_pkg::count_type count;      // Charge counter.
      logic                        ramp_prev;  // Ramp direction last cycle.
      logic                        dir_live;   // Last valid direction, 1 = leaving.
      logic                        dir_latch;  // Direction of the counted unit.
      logic                        int_latch;  // Interrupt latched.
      charge_count_pkg::age_type   int_age;    // Cycles the interrupt has stood.
      logic                        int_oe_n;   // Registered interrupt enable.
      logic                        dir_oe_n;   // Registered direction enable.
      logic                        tracking;   // Settling over.
      logic                        overrange;  // Sticky fast-reversal flag.
      logic                        lost;       // Sticky lost-unit flag.
   } main_state_type;

   // State after reset, sleep or undervoltage: outputs released, count clear.
   localparam main_state_type SLEEP_STATE = '{
      mode: charge_count_pkg::ST_SLEEP, timer: '0, spacing: '0, seen_rev: 1'b0,
      count: charge_count_pkg::COUNT_REF, ramp_prev: 1'b0, dir_live: 1'b0,
      dir_latch: 1'b0, int_latch: 1'b0, int_age: '0, int_oe_n: 1'b1,
      dir_oe_n: 1'b1, tracking: 1'b0, overrange: 1'b0, lost: 1'b0};

   main_state_type s_r;      // Present state.
   main_state_type s_nxt;    // Next state.
   logic           run;      // Counting mode.
   logic           sw_valid; // Switches in a defined position.
   logic           leaving;  // Direction now, 1 = out of the battery.
   logic           reversal; // Ramp changed direction this cycle.
   logic           wrap;     // Counter reaches a wrap point.
   logic           release_int; // Clear releases the interrupt.
   logic           clear_hit;   // Filtered clear.
   charge_count_pkg::count_type step;    // Counter step.
   charge_count_pkg::count_type stepped; // Counter after the step.

   // ************************************************************************
   // Clear filter.
   // ************************************************************************
   clear_width_filter u_clear_filter
   (
      .i_mclk         (i_mclk),
      .i_reset_n      (i_reset_n),
      .i_enable       (run),
      .i_flag_clear_n (i_flag_clear_n),
      .o_clear_hit    (clear_hit)
   );

   // ************************************************************************
   // Event decode.
   // ************************************************************************
   // Derives direction and reversal, and the counter step.
   always_comb
   begin
      run      = (s_r.mode == charge_count_pkg::ST_RUN);
      // Both switches in one position only happens in the break interval.
      sw_valid = i_ramp_switch_a ^ i_ramp_switch_b;
      // Switch A matching the ramp direction means charge leaving; hold while the switches are invalid.
      leaving  = sw_valid ? (i_ramp_switch_a ~^ i_ramp_rising) : s_r.dir_live;
      reversal = run && (i_ramp_rising != s_r.ramp_prev);
      step     = leaving ? charge_count_pkg::COUNT_DOWN : charge_count_pkg::COUNT_UP;
      stepped  = s_r.count + step;
      wrap     = reversal && ((stepped == charge_count_pkg::COUNT_TOP) ||
                              (stepped == charge_count_pkg::COUNT_BOTTOM));
      release_int = s_r.int_latch && clear_hit && (s_r.int_age >= charge_count_pkg::INT_AGE_MIN);
   end

   // ************************************************************************
   // Next state.
   // ************************************************************************
   // Runs the mode sequence, counter, latches and output enables.
   always_comb
   begin
      s_nxt           = s_r;
      s_nxt.ramp_prev = i_ramp_rising;
      s_nxt.dir_live  = leaving;
      case (s_r.mode)
         charge_count_pkg::ST_SLEEP :
         begin
            // Wake into a fresh initialisation interval.
            s_nxt.mode  = charge_count_pkg::ST_INIT;
            s_nxt.timer = '0;
         end
         charge_count_pkg::ST_INIT :
         begin
            // Hold off counting until the interval has passed.
            if (s_r.timer == INIT_LAST)
            begin
               s_nxt.mode  = charge_count_pkg::ST_RUN;
               s_nxt.timer = '0;
            end
            else
            begin
               s_nxt.timer = s_r.timer + 1'b1;
            end
         end
         charge_count_pkg::ST_RUN :
         begin
            // Settling timer for the tracking flag.
            if (s_r.timer == SETTLE_LAST)
            begin
               s_nxt.tracking = 1'b1;
            end
            else
            begin
               s_nxt.timer = s_r.timer + 1'b1;
            end
            // Spacing between reversals, saturating.
            if (s_r.spacing != RAMP_LAST)
            begin
               s_nxt.spacing = s_r.spacing + 1'b1;
            end
            // Age of the latched interrupt, saturating at the minimum.
            if (s_r.int_latch && (s_r.int_age != charge_count_pkg::INT_AGE_MIN))
            begin
               s_nxt.int_age = s_r.int_age + 1'b1;
            end
            // Clear releases both the interrupt and the direction latch.
            if (release_int)
            begin
               s_nxt.int_latch = 1'b0;
            end
            // Counting goes on whatever the latch or clear is doing.
            if (reversal)
            begin
               s_nxt.count   = wrap ? charge_count_pkg::COUNT_REF : stepped;
               s_nxt.spacing = '0;
               s_nxt.seen_rev = 1'b1;
               // Faster than the full-scale ramp means an input excursion.
               if (s_r.seen_rev && (s_r.spacing != RAMP_LAST))
               begin
                  s_nxt.overrange = 1'b1;
               end
            end
            // A wrap sets the latch; it wins over a clear in the same cycle.
            if (wrap)
            begin
               if (s_r.int_latch && !release_int)
               begin
                  s_nxt.lost = 1'b1;
               end
               else
               begin
                  s_nxt.int_latch = 1'b1;
                  s_nxt.dir_latch = leaving;
                  s_nxt.int_age   = '0;
               end
            end
         end
         default :
         begin
            s_nxt = SLEEP_STATE;
         end
      endcase
      // Pins drive only in the counting mode that follows this edge, so the live
      // direction already shows in the first counting cycle; low for charge leaving.
      s_nxt.int_oe_n = !((s_nxt.mode == charge_count_pkg::ST_RUN) && s_nxt.int_latch);
      s_nxt.dir_oe_n = !((s_nxt.mode == charge_count_pkg::ST_RUN) &&
                         (s_nxt.int_latch ? s_nxt.dir_latch : s_nxt.dir_live));
      // Shutdown and undervoltage reset everything and drop the count.
      if (!i_sleep_request_n || i_undervoltage)
      begin
         s_nxt = SLEEP_STATE;
      end
   end

   // ************************************************************************
   // State register.
   // ************************************************************************
   // Registers the state on every edge; power-on reset starts asleep.
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         s_r <= SLEEP_STATE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************************
   // Outputs.
   // ************************************************************************
   assign o_charge_int_n           = 1'b0;
   assign o_charge_int_oe_n        = s_r.int_oe_n;
   assign o_current_direction_out  = 1'b0;
   assign o_current_direction_oe_n = s_r.dir_oe_n;
   assign o_tracking_valid         = s_r.tracking;
   assign o_overrange              = s_r.overrange;
   assign o_count_lost             = s_r.lost;

   // ************************************************************************
   // Checks.
   // ************************************************************************
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   // A sleep pulse followed by its release.
   sequence s_wake;
      !i_sleep_request_n ##1 i_sleep_request_n;
   endsequence

   // A wrap while counting with no interrupt pending.
   sequence s_fresh_wrap;
      run && wrap && !s_r.int_latch && i_sleep_request_n && !i_undervoltage;
   endsequence

   property p_wrap_sets_int;
      (run && wrap && i_sleep_request_n && !i_undervoltage) |=> !o_charge_int_oe_n;
   endproperty
   a_wrap_sets_int : assert property (p_wrap_sets_int) else $error("interrupt not set on wrap");

   property p_dir_latch;
      s_fresh_wrap |=> (o_current_direction_oe_n == !$past(leaving));
   endproperty
   a_dir_latch : assert property (p_dir_latch) else $error("direction not latched with interrupt");

   property p_live_dir;
      (run && !s_r.int_latch) |-> (s_r.dir_oe_n == !s_r.dir_live);
   endproperty
   a_live_dir : assert property (p_live_dir) else $error("direction not live while idle");

   property p_wrap_restart;
      (run && wrap && i_sleep_request_n && !i_undervoltage) |=> (s_r.count == charge_count_pkg::COUNT_REF);
   endproperty
   a_wrap_restart : assert property (p_wrap_restart) else $error("counter not back at reference");

   property p_count_step;
      (reversal && !wrap && i_sleep_request_n && !i_undervoltage)
         |=> (s_r.count == $past(stepped)) && (s_r.count != $past(s_r.count));
   endproperty
   a_count_step : assert property (p_count_step) else $error("reversal not counted");

   property p_release_cause;
      (run && $past(run) && $rose(s_r.int_oe_n))
         |-> ($past(clear_hit) && ($past(s_r.int_age) >= charge_count_pkg::INT_AGE_MIN));
   endproperty
   a_release_cause : assert property (p_release_cause) else $error("interrupt released early");

   property p_sleep_release;
      (!i_sleep_request_n || i_undervoltage)
         |=> (o_charge_int_oe_n && o_current_direction_oe_n && (s_r.count == charge_count_pkg::COUNT_REF));
   endproperty
   a_sleep_release : assert property (p_sleep_release) else $error("sleep did not reset outputs");

   property p_init_hold;
      ((s_r.mode == charge_count_pkg::ST_INIT) && (s_r.timer != INIT_LAST)) |=> !run;
   endproperty
   a_init_hold : assert property (p_init_hold) else $error("counting began before init end");

   property p_wake_init;
      (s_wake ##0 !i_undervoltage) |=> ((s_r.mode == charge_count_pkg::ST_INIT) && (s_r.timer == '0));
   endproperty
   a_wake_init : assert property (p_wake_init) else $error("wake skipped initialisation");

endmodule // charge_count_interrupt_logic

// File: test/host_service_model.sv
`timescale 1ns/10ps
// ****
// Host that services the charge interrupt.
// ****
module host_service_model
(
   input  wire logic        i_mclk,        // Core clock.
   input  wire logic        i_reset_n,     // Reset, active low.
   input  wire logic        i_loop,        // High ties clear to the pin.
   input  wire logic        i_int_wire,    // Interrupt pin level.
   input  wire logic [15:0] i_hold_len,    // Clear low time in cycles.
   output logic             o_flag_clear_n // Clear drive, active low.
);
   logic clr_r; // Clear level from the host routine.
   // Looped mode passes the pin level straight back.
   assign o_flag_clear_n = i_loop ? i_int_wire : clr_r;
   // Waits for a flag, pulses clear low, then after 20 cycles looks for a flag again, pulsing again if the same one still stands.
   initial
   begin
      clr_r = 1'b1;
      forever
      begin
         @(posedge i_mclk);
         if (!i_loop && i_reset_n && i_int_wire === 1'b0)
         begin
            repeat (5) @(posedge i_mclk);
            clr_r <= 1'b0;
            repeat (i_hold_len) @(posedge i_mclk);
            clr_r <= 1'b1;
            repeat (20) @(posedge i_mclk);
         end
      end
   end
endmodule // host_service_model

// File: test/charge_count_interrupt_logic_tb.sv
`timescale 1ns/10ps
// ****
// Self-checking bench for the charge counter.
// ****
module charge_count_interrupt_logic_tb;
   localparam int INIT = 20;          // Short initialisation.
   localparam int SETTLE = 40;        // Short settling.
   logic i_mclk = 1'b0;               // Core clock.
   logic rst_n = 1'b0;                // Reset drive.
   logic sleep_n = 1'b1;              // Sleep request drive.
   logic uv = 1'b0;                   // Undervoltage drive.
   logic ramp = 1'b0;                 // Ramp direction drive.
   logic sw_a = 1'b0;                 // Switch A drive.
   logic sw_b = 1'b1;                 // Switch B drive.
   logic loop = 1'b0;                 // Looped clear mode.
   logic [15:0] hold = 16'h01f4;      // Host clear length, 500 first.
   logic clr_n, int_lvl, int_oe_n;    // Clear and interrupt pin.
   logic dir_lvl, dir_oe_n;           // Direction pin.
   logic track, ovr, lost;            // Status outputs.
   wire int_wire = int_oe_n ? 1'b1 : int_lvl; // Pulled-up pin.
   wire dir_wire = dir_oe_n ? 1'b1 : dir_lvl; // Pulled-up pin.
   int err_total = 0;                 // Mismatches.
   int comparisons = 0;               // Comparisons made.
   int seed = 95;                     // Random seed.
   int cnt = 0;                       // Model of the signed counter.
   int total = 0;                     // Reversals driven by rev so far.
   int run = 0;                       // Consecutive clear low samples.
   int width = 0;                     // Interrupt low samples.
   logic prev = 1'b1;                 // Pin level at the last edge.
   logic [11:0] exp_q[$];             // Expected {direction, total}.

   // The clock toggles every half period.
   always #10 i_mclk = ~i_mclk;

   charge_count_interrupt_logic #(.INIT_CYC(INIT), .SETTLE_CYC(SETTLE), .RAMP_FS_CYC(10)) uut
   (.i_mclk(i_mclk), .i_reset_n(rst_n), .i_sleep_request_n(sleep_n), .i_undervoltage(uv),
    .i_ramp_rising(ramp), .i_ramp_switch_a(sw_a), .i_ramp_switch_b(sw_b), .i_flag_clear_n(clr_n),
    .o_charge_int_n(int_lvl), .o_charge_int_oe_n(int_oe_n), .o_current_direction_out(dir_lvl),
    .o_current_direction_oe_n(dir_oe_n), .o_tracking_valid(track), .o_overrange(ovr),
    .o_count_lost(lost));

   host_service_model host
   (.i_mclk(i_mclk), .i_reset_n(rst_n), .i_loop(loop), .i_int_wire(int_wire),
    .i_hold_len(hold), .o_flag_clear_n(clr_n));

   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Drives n reversals at random legal spacing and notes each wrap.
   task automatic rev(input int n, input logic leaving);
      for (int i = 0; i < n; i++)
      begin
         repeat (11 + ($unsigned($random(seed)) % 3)) @(posedge i_mclk);
         sw_a <= leaving ? ~ramp : ramp;
         sw_b <= leaving ? ramp : ~ramp;
         ramp <= ~ramp;
         total++;
         cnt += leaving ? -1 : 1;
         if (cnt == 1024 || cnt == -1024)
         begin
            cnt = 0;
            exp_q.push_back({~leaving, total[10:0]});
         end
      end
   endtask

   // Toggles the ramp three times on successive edges.
   task automatic idle_toggles;
      repeat (3)
      begin
         @(posedge i_mclk);
         ramp <= ~ramp;
      end
   endtask

   // Waits a bounded time for the interrupt pin to release.
   task automatic wait_release;
      int k;
      k = 0;
      while (int_wire !== 1'b1 && k < 4000)
      begin
         @(negedge i_mclk);
         k++;
      end
      if (k == 4000)
      begin
         err_total++;
         complete_run;
      end
   endtask

   // Takes the oldest note whenever the pin falls; checks clear width on release.
   always @(posedge i_mclk)
   begin
      if (rst_n !== 1'b1 || sleep_n !== 1'b1 || uv !== 1'b0)
      begin
         prev = 1'b1;
         run = 0;
         width = 0;
      end
      else
      begin
         if (prev === 1'b1 && int_wire === 1'b0)
         begin
            if (exp_q.size() == 0)
               check(12'hfff, 12'h000);
            else
               check({dir_wire, total[10:0]}, exp_q.pop_front());
         end
         if (prev === 1'b0 && int_wire === 1'b1)
         begin
            check(12'(run > charge_count_pkg::CLEAR_CYC), 12'h001);
            check(12'(width >= charge_count_pkg::INT_MIN_CYC), 12'h001);
         end
         width = (int_wire === 1'b0) ? width + 1 : 0;
         run = (clr_n === 1'b0) ? run + 1 : 0;
         prev = int_wire;
      end
   end

   // Main sequence.
   initial
   begin
      repeat (4) @(posedge i_mclk);
      rst_n <= 1'b1;
      idle_toggles();
      repeat (INIT + 10) @(posedge i_mclk);
      rev(1024, 1'b0);
      repeat (3000) @(posedge i_mclk);
      check({11'h0, int_wire}, 12'h000);
      $display("Test entering wrap and short clear done");
      hold <= 16'h044c;
      rev(1024, 1'b1);
      rev(3, 1'b0);
      @(negedge i_mclk);
      check({11'h0, dir_wire}, 12'h000);
      wait_release();
      repeat (2) @(negedge i_mclk);
      check({11'h0, dir_wire}, 12'h001);
      $display("Test leaving wrap and host clear done");
      repeat (200) @(posedge i_mclk);
      loop <= 1'b1;
      rev(1021, 1'b0);
      repeat (1500) @(posedge i_mclk);
      $display("Test looped clear done");
      for (int s = 0; s < 2; s++)
      begin
         rev(300, 1'b0);
         @(posedge i_mclk);
         sleep_n <= (s != 0);
         uv <= (s != 0);
         repeat (3) @(negedge i_mclk);
         check({10'h0, int_oe_n, dir_oe_n}, 12'h003);
         @(posedge i_mclk);
         sleep_n <= 1'b1;
         uv <= 1'b0;
         cnt = 0;
         idle_toggles();
         @(negedge i_mclk);
         check({11'h0, track}, 12'h000);
         repeat (INIT + SETTLE + 10) @(posedge i_mclk);
         check({11'h0, track}, 12'h001);
         rev(1024, 1'b0);
         repeat (1500) @(posedge i_mclk);
      end
      $display("Test sleep and undervoltage done");
      check({9'h0, 1'(exp_q.size() != 0), ovr, lost}, 12'h000);
      // Back-to-back reversals while counting must raise the fast-reversal flag.
      idle_toggles();
      repeat (2) @(negedge i_mclk);
      check({11'h0, ovr}, 12'h001);
      $display("Test fast reversal flag done");
      complete_run();
   end
endmodule // charge_count_interrupt_logic_tb
